// ---- rtl/bti_i2c_bit_ctrl.sv ----
// Single-bit two-wire bus controller with flags, stretching and timer.
// Assumes firmware drives strobes for one clk cycle; pins are open drain
// and resolved outside; scl_clk is the bus clock pin used as a clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Idle write ignores bus until next start
// - Data-ready cleared by strobe or data access
// - Each clear strobe clears only its flag
// - Hold clock low while any flag set
// - Repeated start sends one, then pulls data
// - First start generated automatically on mastership
// - Stop sends zero, then releases data line
// - Slave, request and mastership all off means disabled, timer held cleared
// - Timer run off: only low bits count
// - Timer counts in frames, cleared by edges
// - Prescale picks min time and timeout
// - Timeout resets interface, raises timer interrupt
// - Service request is OR of flags
// - Drive data (save the master's first start pull) or lose arbitration only transmitting
// - Data ready on clock rise unless idle
module bti_i2c_bit_ctrl
  import bti_pkg::*;
(
  // Clocks and reset
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire logic      scl_clk,
  // Firmware configuration and strobes
  input  wire bti_cfg_t  cfg,
  input  wire bti_ctl_t  ctl,
  // Bit data register access
  input  wire logic      dat_rd,
  input  wire logic      dat_wr,
  input  wire logic      transmit_bit,
  // Status
  output bti_stat_t      stat,
  output logic           bus_timer_irq,
  // Clock line, open drain
  input  wire logic      scl_i,
  output logic           scl_o,
  output logic           scl_oe,
  // Data line, open drain
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe
);

  // ==================================================
  // Link side: capture data at each clock rise
  logic rx_link_q;  // Data sampled on scl_clk

  // Sample data line on the bus clock
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      rx_link_q <= 1'b0;
    end else begin
      rx_link_q <= sda_i;
    end
  end

  // ==================================================
  // Pin and link synchronisers
  logic [2:0] syn;    // {rx, sda, scl} in clk domain
  bti_sync #(.W(3)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({rx_link_q, sda_i, scl_i}),
    .q    (syn)
  );
  wire s_scl = syn[0];  // Clock line level
  wire s_sda = syn[1];  // Data line level
  wire s_rx  = syn[2];  // Received bit

  // ==================================================
  // State
  logic     scl_p_q;   // Clock line last cycle
  logic     sda_p_q;   // Data line last cycle
  logic     data_ready_flag_q;    // Data ready
  logic     arl_q;     // Arbitration loss
  logic     str_q;     // Start seen
  logic     stp_q;     // Stop seen
  logic     mst_q;     // Current master
  logic     busy_q;    // Frame in progress
  logic     idle_q;    // Ignoring bus until start
  logic     xmit_q;    // Transmit active
  logic     sdl_q;     // Pull data low when transmitting
  logic     rs_q;      // Repeated start pending
  logic     sp_q;      // Stop pending
  logic     ssda_q;    // Initial start data pull
  logic     hold_q;    // Clock stretch
  bti_mst_t st_q;      // Master sequencer
  bti_mst_t st_d;
  logic     min_done;  // Min time elapsed
  logic     tout;      // Timer carry out

  // ==================================================
  // Bus events
  wire scl_rise  = s_scl & ~scl_p_q;
  wire scl_fall  = ~s_scl & scl_p_q;
  wire start_det = s_scl & scl_p_q & sda_p_q & ~s_sda;
  wire stop_det  = s_scl & scl_p_q & ~sda_p_q & s_sda;

  // Mode decode
  wire enabled = cfg.slave_enable | cfg.master_request | mst_q;
  wire listen  = enabled & ~(idle_q & ~mst_q);
  wire attn    = data_ready_flag_q | arl_q | str_q | stp_q;
  wire [1:0] pre_x = {cfg.prescale_high_bit, cfg.prescale_low_bit};  // Two-bit code

  // Arbitration loss only while transmitting a released line
  wire arl_set = listen & xmit_q & ~sdl_q &
                 ((scl_rise & ~s_sda) | start_det);

  // Mastership gained when bus free
  wire mst_set = ~mst_q & cfg.master_request & ~busy_q & ~arl_set;
  wire mst_clr = arl_set | tout | (stop_det & ~cfg.master_request);

  // Special condition due now in clock high
  wire act = (st_q == MS_HIGH) & s_scl & min_done &
             xmit_q & (rs_q | sp_q);

  // Firmware transmit loads
  wire ld_bit = dat_wr;
  wire ld_rs  = ctl.send_repeated_start_request;
  wire ld_sp  = ctl.send_stop_request;
  wire ld_any = ld_bit | ld_rs | ld_sp;

  // ==================================================
  // Master sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      MS_OFF: begin
        if (mst_set) begin
          st_d = MS_START;  // Start made by hardware
        end
      end
      MS_START: begin
        if (ssda_q && busy_q && min_done) begin
          st_d = MS_LOW;
        end
      end
      MS_LOW: begin
        if (min_done && !attn) begin
          st_d = MS_HIGH;
        end
      end
      MS_HIGH: begin
        if (s_scl && min_done && !act && !(xmit_q && (rs_q || sp_q))) begin
          st_d = MS_LOW;
        end else if (stop_det) begin
          st_d = MS_START;
        end
      end
      default: begin
        st_d = MS_OFF;
      end
    endcase
    if (mst_clr || (!mst_q && st_q != MS_OFF)) begin
      st_d = MS_OFF;
    end
  end

  // Timer clear: edges, conditions, steps, disable
  wire step    = (st_d != st_q) | act;
  wire tmr_clr = scl_rise | scl_fall | start_det | stop_det | step | tout;

  // ==================================================
  // Bus timer
  bti_bus_timer u_tmr (
    .clk      (clk),
    .rstn     (rstn),
    .clr      (tmr_clr),
    .run_lo   (enabled),
    .run_hi   (cfg.bus_timer_run & busy_q),
    .pre      (pre_x),
    .min_done (min_done),
    .timeout  (tout)
  );

  // ==================================================
  // Status flags: set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_ready_flag_q <= 1'b0;
      arl_q  <= 1'b0;
      str_q  <= 1'b0;
      stp_q  <= 1'b0;
    end else if (tout) begin
      // Timeout resets the interface
      data_ready_flag_q <= 1'b0;
      arl_q  <= 1'b0;
      str_q  <= 1'b0;
      stp_q  <= 1'b0;
    end else begin
      data_ready_flag_q <= (listen & scl_rise) |
                (data_ready_flag_q & ~(ctl.clear_data_ready_strobe | dat_rd | dat_wr));
      // Own clear strobe only
      arl_q  <= arl_set | (arl_q & ~ctl.clear_arbitration_loss);
      str_q  <= (listen & start_det) | (str_q & ~ctl.clear_start_seen);
      stp_q  <= (listen & stop_det) | (stp_q & ~ctl.clear_stop_seen);
    end
  end

  // ==================================================
  // Bus state, mastership and idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      mst_q  <= 1'b0;
      idle_q <= IDLE_RST;
      st_q   <= MS_OFF;
    end else begin
      st_q <= st_d;
      // Frame tracking
      if (stop_det || tout) begin
        busy_q <= 1'b0;
      end else if (start_det) begin
        busy_q <= 1'b1;
      end
      // Mastership; stop at idle slave may grant it
      if (mst_clr) begin
        mst_q <= 1'b0;
      end else if (mst_set) begin
        mst_q <= 1'b1;
      end
      // Ignore until start
      if (ctl.idle_write) begin
        idle_q <= 1'b1;
      end else if (start_det || mst_set) begin
        idle_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // Transmit path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xmit_q <= 1'b0;
      sdl_q  <= 1'b0;
      rs_q   <= 1'b0;
      sp_q   <= 1'b0;
    end else if (tout || arl_set) begin
      // Loss or timeout drops transmit
      xmit_q <= 1'b0;
      rs_q   <= 1'b0;
      sp_q   <= 1'b0;
    end else if (ld_any) begin
      xmit_q <= 1'b1;
      rs_q   <= ld_rs;
      sp_q   <= ld_sp & ~ld_rs;
      if (ld_rs) begin
        sdl_q <= 1'b0;  // Release high during low
      end else if (ld_sp) begin
        sdl_q <= 1'b1;  // Pull low during low
      end else begin
        sdl_q <= ~transmit_bit;
      end
    end else if (act) begin
      rs_q <= 1'b0;
      sp_q <= 1'b0;
      if (rs_q) begin
        sdl_q <= 1'b1;  // Data low after min time
      end else begin
        sdl_q  <= 1'b0; // Data released: stop
        xmit_q <= 1'b0;
      end
    end else if (dat_rd || ctl.clear_xmit_active) begin
      xmit_q <= 1'b0;
    end
  end

  // ==================================================
  // Initial start pull and clock stretch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ssda_q  <= 1'b0;
      hold_q  <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= s_scl;
      sda_p_q <= s_sda;
      // Pull data low after bus free time
      if (st_q != MS_START) begin
        ssda_q <= 1'b0;
      end else if (min_done && s_scl) begin
        ssda_q <= 1'b1;
      end
      // Stretch once low while flags pending
      hold_q <= attn & listen & ~tout & (hold_q | ~s_scl);
    end
  end

  // ==================================================
  // Pin drive, open drain
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = hold_q | (st_q == MS_LOW);
  assign sda_oe = (xmit_q & sdl_q) | ((st_q == MS_START) & ssda_q);

  // Timer interrupt when enabled
  assign bus_timer_irq = tout & cfg.bus_timer_irq_enable;

  // ==================================================
  // Status out
  assign stat.service_request_flag  = attn;
  assign stat.data_ready_flag       = data_ready_flag_q;
  assign stat.arbitration_loss_flag = arl_q;
  assign stat.start_seen_flag       = str_q;
  assign stat.stop_seen_flag        = stp_q;
  assign stat.master                = mst_q;
  assign stat.xmit_active           = xmit_q;
  assign stat.rx_data               = s_rx;

endmodule

// ---- shared/bti_pkg.sv ----
// Package for the single-bit two-wire bus controller with its bus timer.
// Assumes one machine cycle per clk cycle; shared by the controller, bus timer, checker and bench top.
package bti_pkg;

  // ==================================================
  // Bus timer geometry
  localparam int unsigned TMR_W    = 10;  // Full timer width
  localparam int unsigned TMR_LO_W = 3;   // Min-time part of the timer

  // Preloads: min time = 8 - preload, timeout = 1024 - preload
  localparam logic [2:0] PRE_CODE_10 = 3'h1;  // 7 and 1023 cycles
  localparam logic [2:0] PRE_CODE_01 = 3'h2;  // 6 and 1022 cycles
  localparam logic [2:0] PRE_CODE_00 = 3'h3;  // 5 and 1021 cycles
  localparam logic [2:0] PRE_CODE_11 = 3'h4;  // 4 and 1020 cycles

  // Reset values of control state
  localparam logic IDLE_RST = 1'b1;  // Slave ignores bus until a start

  // ==================================================
  // Master sequencer states, one-hot
  typedef enum logic [3:0] {
    MS_OFF   = 4'b0001,
    MS_START = 4'b0010,
    MS_LOW   = 4'b0100,
    MS_HIGH  = 4'b1000
  } bti_mst_t;

  // ==================================================
  // Configuration levels from firmware
  typedef struct packed {
    logic slave_enable;
    logic master_request;
    logic bus_timer_run;
    logic prescale_high_bit;
    logic prescale_low_bit;
    logic bus_timer_irq_enable;
  } bti_cfg_t;

  // Control strobes, one cycle each, read back as zero
  typedef struct packed {
    logic idle_write;
    logic clear_data_ready_strobe;
    logic clear_arbitration_loss;
    logic clear_start_seen;
    logic clear_stop_seen;
    logic clear_xmit_active;
    logic send_repeated_start_request;
    logic send_stop_request;
  } bti_ctl_t;

  // Status seen by firmware
  typedef struct packed {
    logic service_request_flag;
    logic data_ready_flag;
    logic arbitration_loss_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
    logic master;
    logic xmit_active;
    logic rx_data;
  } bti_stat_t;

  // ==================================================
  // Prescale code to timer preload
  function automatic logic [2:0] bti_preload(input logic [1:0] code);
    logic [2:0] p;
    p = PRE_CODE_00;
    if (code == 2'h2) begin
      p = PRE_CODE_10;
    end else if (code == 2'h1) begin
      p = PRE_CODE_01;
    end else if (code == 2'h3) begin
      p = PRE_CODE_11;
    end
    return p;
  endfunction

endpackage

// ---- rtl/bti_sync.sv ----
// Two-flop level synchroniser, one per bit.
// Assumes inputs are levels from another clock or a pin.
`timescale 1ns/1ps
module bti_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==================================================
  // Synchroniser chains
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;  // First stage, read only by second
      logic sync_q;  // Second stage
      // Two flops in series
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule

// ---- rtl/bti_bus_timer.sv ----
// Ten-bit bus timer: min-time flag from the low bits, timeout pulse.
// Assumes clear and run inputs come from the controller on clk.
`timescale 1ns/1ps
module bti_bus_timer
  import bti_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control
  input  wire logic       clr,
  input  wire logic       run_lo,
  input  wire logic       run_hi,
  input  wire logic [1:0] pre,
  // Results
  output logic            min_done,
  output logic            timeout
);

  logic [TMR_W-1:0] cnt_q;   // Timer count
  logic [TMR_W-1:0] cnt_d;
  logic             min_q;   // Min time elapsed
  logic             min_d;
  logic             tout_q;  // Carry out pulse
  logic             tout_d;

  // ==================================================
  // Count decode
  wire             lo_carry = &cnt_q[TMR_LO_W-1:0];
  wire             full     = &cnt_q;
  wire [TMR_W-1:0] load     = {{(TMR_W-TMR_LO_W){1'b0}}, bti_preload(pre)};
  wire [TMR_LO_W-1:0] lo_inc = cnt_q[TMR_LO_W-1:0] + 3'h1;
  wire [TMR_W-TMR_LO_W-1:0] hi_inc = cnt_q[TMR_W-1:TMR_LO_W] + 7'h01;

  // Next state
  always_comb begin
    cnt_d  = cnt_q;
    min_d  = min_q;
    tout_d = 1'b0;
    if (clr || !run_lo) begin
      // Held cleared while disabled
      cnt_d = load;
      min_d = 1'b0;
    end else begin
      cnt_d[TMR_LO_W-1:0] = lo_inc;  // Low bits always run
      if (lo_carry) begin
        min_d = 1'b1;
      end
      if (lo_carry && run_hi) begin
        // Upper bits only during frames
        cnt_d[TMR_W-1:TMR_LO_W] = hi_inc;
      end
      tout_d = run_hi && full;  // Carry out of all bits
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      min_q  <= 1'b0;
      tout_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      min_q  <= min_d;
      tout_q <= tout_d;
    end
  end

  assign min_done = min_q;
  assign timeout  = tout_q;

endmodule

// ---- bench/bti_i2c_bit_ctrl_assertions.sv ----
// Checker for the two-wire bit controller, watching its ports only.
// Assumes one clk domain for all flags; bound to every controller.
`timescale 1ns/1ps
module bti_i2c_bit_ctrl_chk
  import bti_pkg::*;
(
  // Clocks and reset
  input wire logic      clk,
  input wire logic      rstn,
  input wire logic      scl_clk,
  // Firmware side
  input wire bti_cfg_t  cfg,
  input wire bti_ctl_t  ctl,
  input wire logic      dat_rd,
  input wire logic      dat_wr,
  input wire logic      transmit_bit,
  input wire bti_stat_t stat,
  input wire logic      bus_timer_irq,
  // Bus pins
  input wire logic      scl_i,
  input wire logic      scl_o,
  input wire logic      scl_oe,
  input wire logic      sda_i,
  input wire logic      sda_o,
  input wire logic      sda_oe
);
  // ==================================================
  // Quiet bus tracking
  logic [2:0] qt_q;   // Steady cycles, saturating
  logic       qs_q;   // Last clock line
  logic       qd_q;   // Last data line
  logic       quiet;  // No edge can still be in flight
  logic [3:0] flg;    // The four service flags
  assign quiet = (qt_q >= 3'h6);
  assign flg = {stat.data_ready_flag, stat.arbitration_loss_flag,
                stat.start_seen_flag, stat.stop_seen_flag};
  // Count cycles since either pin moved
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qt_q <= 3'h0;
      qs_q <= 1'b1;
      qd_q <= 1'b1;
    end else begin
      qs_q <= scl_i;
      qd_q <= sda_i;
      qt_q <= (scl_i != qs_q || sda_i != qd_q) ? 3'h0 : (qt_q == 3'h7 ? qt_q : qt_q + 3'h1);
    end
  end

  // ==================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  srq_or_a: assert property (stat.service_request_flag == (|flg))
    else $error("service flag differs from OR of flags");
  sda_xa_a: assert property (sda_oe && !stat.master && !cfg.master_request
    |-> stat.xmit_active || $past(stat.xmit_active)) else $error("data pulled while idle");
  wr_sda_a: assert property (dat_wr && scl_oe && quiet
    |=> stat.xmit_active && sda_oe == !$past(transmit_bit)) else $error("bad data drive");
  dr_clr_a: assert property ((ctl.clear_data_ready_strobe || dat_rd || dat_wr)
    && quiet |=> !stat.data_ready_flag) else $error("data ready not cleared");
  stp_clr_a: assert property (ctl.clear_stop_seen && quiet |=> !stat.stop_seen_flag)
    else $error("stop flag not cleared");
  own_flag_a: assert property (ctl.clear_stop_seen && !ctl.clear_data_ready_strobe
    && !dat_rd && !dat_wr && stat.data_ready_flag && quiet && !cfg.bus_timer_run
    |=> stat.data_ready_flag) else $error("strobe cleared a foreign flag");
  stretch_a: assert property (stat.service_request_flag && !scl_i && quiet |-> scl_oe)
    else $error("clock not held while flags pend");
  rel_a: assert property ((!stat.master && !stat.service_request_flag) [*3]
    |-> !scl_oe) else $error("clock held without flags");
  tmo_rst_a: assert property (bus_timer_irq |-> ##2 !stat.service_request_flag
    && !stat.master && !scl_oe) else $error("timeout left interface busy");
  tmo_gate_a: assert property (bus_timer_irq |-> cfg.bus_timer_irq_enable
    && cfg.bus_timer_run && qt_q == 3'h7) else $error("timeout out of place");
  // Main scenarios reached
  cover property (bus_timer_irq);
  cover property (stat.data_ready_flag && scl_oe);
  cover property (ctl.clear_stop_seen && stat.stop_seen_flag);
endmodule

bind bti_i2c_bit_ctrl bti_i2c_bit_ctrl_chk chk_u (.clk(clk), .rstn(rstn), .scl_clk(scl_clk),
  .cfg(cfg), .ctl(ctl), .dat_rd(dat_rd), .dat_wr(dat_wr), .transmit_bit(transmit_bit),
  .stat(stat), .bus_timer_irq(bus_timer_irq), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// ---- bench/bti_bus_model.sv ----
// Partner on the two-wire bus: another master clocking bits every 55 ns unless stretched.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
module bti_bus_model (
  // Resolved clock line
  input  wire logic scl,
  // Pull-down enables, high pulls low
  output logic      scl_pd,
  output logic      sda_pd
);
  localparam int HALF = 24;  // Half link period in ns
  // Lines released at time zero
  initial begin
    scl_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // Start: data falls under a high clock, then clock low
  task automatic start();
    #7;
    sda_pd = 1'b1;
    #HALF;
    scl_pd = 1'b1;
    #HALF;
  endtask
  // One bit: data set in clock low, stretching waited out
  task automatic bit_out(input logic b);
    #7;
    sda_pd = !b;
    #HALF;
    scl_pd = 1'b0;
    wait (scl === 1'b1);
    #HALF;
    scl_pd = 1'b1;
  endtask
  // Stop: data low, clock up, then data released under high clock
  task automatic stop();
    #7;
    sda_pd = 1'b1;
    #HALF;
    scl_pd = 1'b0;
    wait (scl === 1'b1);
    #HALF;
    sda_pd = 1'b0;
    #HALF;
  endtask
endmodule

// ---- bench/bti_i2c_bit_ctrl_tb_top.sv ----
// Testbench top for the two-wire bit controller with its bus partner.
// Assumes the checker binds itself; lines resolve open drain with pull-ups.
`timescale 1ns/1ps
module bti_i2c_bit_ctrl_tb_top
  import bti_pkg::*;
;
  logic      clk;           // Machine clock
  logic      rstn;          // Reset, active low
  bti_cfg_t  cfg;           // Configuration levels
  bti_ctl_t  ctl;           // Strobes
  logic      dat_rd;        // Data register read
  logic      dat_wr;        // Data register write
  logic      transmit_bit;  // Bit written
  bti_stat_t stat;          // Status
  logic      bus_timer_irq; // Timeout pulse
  logic      scl_o, scl_oe, sda_o, sda_oe;
  logic      m_scl, m_sda;  // Partner pull-downs
  wire logic scl, sda;      // Resolved lines
  int        miscompares, cmp_count;
  assign scl = !((scl_oe && !scl_o) || m_scl);
  assign sda = !((sda_oe && !sda_o) || m_sda);

  bti_i2c_bit_ctrl dut_u (.clk(clk), .rstn(rstn), .scl_clk(scl), .cfg(cfg), .ctl(ctl),
    .dat_rd(dat_rd), .dat_wr(dat_wr), .transmit_bit(transmit_bit), .stat(stat),
    .bus_timer_irq(bus_timer_irq), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  bti_bus_model bm_u (.scl(scl), .scl_pd(m_scl), .sda_pd(m_sda));

  // ==================================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    cmp_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH t=%0t %s %0d", $time, what, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_cfg(input logic [5:0] v);
    @(posedge clk);
    cfg <= v;
  endtask
  // One firmware access: strobes and data access for one cycle
  task automatic fw(input logic [7:0] c, input logic rd, input logic wr, input logic b);
    @(posedge clk);
    ctl <= c;
    dat_rd <= rd;
    dat_wr <= wr;
    transmit_bit <= b;
    @(posedge clk);
    ctl <= 8'h00;
    dat_rd <= 1'b0;
    dat_wr <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wt(2);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==================================================
  // Scenarios
  task automatic t_reset();
    chk(stat.service_request_flag, 1'b0, "flags after reset");
    chk(stat.master, 1'b0, "master after reset");
    chk(scl_oe, 1'b0, "clock after reset");
    chk(sda_oe, 1'b0, "data after reset");
    $display("test reset done");
  endtask
  // Slave frame: idle start, bits both ways, stop, single clears
  task automatic t_frame();
    set_cfg(6'h20);
    bm_u.start();
    wt(8);
    chk(stat.start_seen_flag, 1'b0, "idle start flagged");
    bm_u.bit_out(1'b1);
    wt(8);
    chk(stat.data_ready_flag, 1'b1, "no ready on rise");
    chk(stat.service_request_flag, 1'b1, "no service flag");
    chk(scl_oe, 1'b1, "clock not stretched");
    chk(stat.rx_data, 1'b1, "received one");
    fw(8'h00, 1'b0, 1'b1, 1'b0);
    chk(stat.data_ready_flag, 1'b0, "write kept ready");
    chk(sda_oe, 1'b1, "zero not driven");
    chk(stat.xmit_active, 1'b1, "write left transmit idle");
    wt(3);
    chk(scl_oe, 1'b0, "clock not freed");
    bm_u.bit_out(1'b1);
    wt(8);
    chk(stat.rx_data, 1'b0, "received zero");
    fw(8'h00, 1'b1, 1'b0, 1'b0);
    chk(stat.data_ready_flag, 1'b0, "read kept ready");
    chk(sda_oe, 1'b0, "data held after read");
    chk(stat.xmit_active, 1'b0, "read kept transmit");
    bm_u.stop();
    wt(8);
    chk(stat.stop_seen_flag, 1'b1, "stop missed");
    fw(8'h08, 1'b0, 1'b0, 1'b0);
    chk(stat.stop_seen_flag, 1'b0, "stop not cleared");
    chk(stat.data_ready_flag, 1'b1, "ready lost");
    fw(8'h40, 1'b0, 1'b0, 1'b0);
    chk(stat.data_ready_flag, 1'b0, "strobe kept ready");
    $display("test frame done");
  endtask
  // Hung bus: timeout span per prescale code, then interface freed
  task automatic t_tmo();
    int exp_n[4] = '{1021, 1022, 1023, 1020};
    int n;
    for (int c = 0; c < 4; c++) begin
      wt(6);
      fw(8'hF8, 1'b0, 1'b0, 1'b0);
      set_cfg({3'h5, 2'(c), 1'h1});
      bm_u.start();
      bm_u.bit_out(1'b1);
      n = 0;
      while (bus_timer_irq !== 1'b1 && n < 1100) begin
        wt(1);
        n++;
      end
      chk_rng(n, exp_n[c] - 1, exp_n[c] + 7, "timeout span");
      wt(3);
      chk(stat.service_request_flag, 1'b0, "flags after timeout");
      chk(scl_oe, 1'b0, "clock held after timeout");
      bm_u.stop();
    end
    wt(8);
    fw(8'hF8, 1'b0, 1'b0, 1'b0);
    $display("test timeout done");
  endtask
  // Mastership: own start made on the master request, then stretching
  task automatic t_master();
    int n;
    set_cfg(6'h30);
    n = 0;
    while (stat.master !== 1'b1 && n < 200) begin
      wt(1);
      n++;
    end
    chk(stat.master, 1'b1, "no mastership");
    wt(20);
    chk(stat.start_seen_flag, 1'b1, "own start unseen");
    chk(scl_oe, 1'b1, "master clock not held");
    set_cfg(6'h20);
    set_cfg(6'h00);
    do_reset();
    $display("test master done");
  endtask

  // ==================================================
  // Main sequence and watchdog
  initial begin
    rstn = 1'b0;
    cfg = 6'h00;
    ctl = 8'h00;
    dat_rd = 1'b0;
    dat_wr = 1'b0;
    transmit_bit = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    do_reset();
    t_reset();
    t_frame();
    t_tmo();
    t_master();
    t_reset();
    complete_run();
  end
  initial begin
    #500000;
    miscompares++;
    $display("MISMATCH t=%0t watchdog", $time);
    complete_run();
  end
endmodule
